// ===== blc_regs.sv
/*
 Package for the bit-logic and call slice of the core, plus its data
 register file. Assumes one clock (MCLK) and an active-low async reset.
*/
`timescale 1ns/1ps
package blc_pkg;
   localparam int DATA_W = 8;
   localparam int RADDR_W = 7;
   localparam int BIT_W = 3;
   localparam int PAGE_BITS = 3;
   localparam int PC_W = 11;
   localparam int STACK_DEPTH = 8;
   // All ones, so the first and-immediate after reset passes its operand
   localparam logic [DATA_W-1:0] WORK_RESET = 8'hFF;
   localparam logic [DATA_W-1:0] WORK_CLEARED = 8'h00;
   localparam logic ZERO_RESET = 1'b0;
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   localparam logic [PC_W-1:0] PC_STEP = 11'h001;

   typedef enum logic [2:0] {
      NOP_OP = 3'h0,
      AND_IMMEDIATE_OP = 3'h1,
      BIT_SET_OP = 3'h2,
      BIT_CLEAR_OP = 3'h3,
      TEST_SKIP_IF_CLEAR_OP = 3'h4,
      TEST_SKIP_IF_SET_OP = 3'h5,
      INDIRECT_CALL_OP = 3'h6,
      CLEAR_WORKING_OP = 3'h7
   } blc_op_t;

   typedef struct packed {
      blc_op_t op;
      logic [RADDR_W-1:0] addr;
      logic [BIT_W-1:0] bit_sel;
      logic [DATA_W-1:0] imm;
   } blc_instr_t;

   typedef enum logic [1:0] {
      ST_EXEC = 2'b00,
      ST_CALL2 = 2'b01
   } blc_state_t;
endpackage

module blc_data_regs
#(
   parameter int DW = 8,
   parameter int AW = 7
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data,
   input wire logic [AW-1:0] peek_addr,
   output logic [DW-1:0] peek_q
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Combinational read so a test or read-modify-write finishes in one cycle
   assign rd_data = mem[rd_addr];

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         peek_q <= '0;
      end
      else
      begin
         peek_q <= mem[peek_addr];
      end
   end
endmodule

// ===== blc_core.sv
/*
 Execution slice: and-immediate, bit set/clear, bit test and skip,
 indirect call and clear of the working register. Assumes the fetch
 logic on MCLK offers one instruction at a time with INSTR_VALID and
 holds it until INSTR_READY takes it.
*/
`timescale 1ns/1ps
module blc_core
   import blc_pkg::*;
#(
   parameter int STACK_N = blc_pkg::STACK_DEPTH
)
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic INSTR_VALID,
   input wire blc_pkg::blc_instr_t INSTR,
   input wire logic [blc_pkg::DATA_W-1:0] PAGE_PTR,
   input wire logic [blc_pkg::RADDR_W-1:0] PEEK_ADDR,
   output logic INSTR_READY,
   output logic [blc_pkg::DATA_W-1:0] WORK_REG,
   output logic ZERO_FLAG,
   output logic [blc_pkg::PC_W-1:0] PROG_CNT,
   output logic [$clog2(STACK_N)-1:0] STACK_PTR,
   output logic [blc_pkg::PC_W-1:0] STACK_TOP,
   output logic SKIP_PEND,
   output logic [blc_pkg::DATA_W-1:0] PEEK_DATA
);
   import blc_pkg::*;
   localparam int SPW = $clog2(STACK_N);

   // Pointer wraps by plain overflow, so only a power-of-two depth works
   if (STACK_N < 2 || (1 << SPW) != STACK_N)
   begin : g_bad_depth
      $error("STACK_N must be a power of two of at least 2");
   end
   if (PC_W != DATA_W + PAGE_BITS)
   begin : g_bad_width
      $error("Counter width must be page bits plus data width");
   end

   logic [DATA_W-1:0] work_q, work_d;
   logic zero_q, zero_d;
   logic [PC_W-1:0] pc_q, pc_d;
   logic [SPW-1:0] sp_q;
   logic skip_q, skip_d;
   logic ready_q;
   blc_state_t state_q;
   logic [PC_W-1:0] stack_mem [0:STACK_N-1];
   logic [PC_W-1:0] top_q;
   logic [DATA_W-1:0] peek_data;

   wire take = INSTR_VALID && ready_q;
   // A taken skip turns the next instruction into a no-op
   wire exec = take && !skip_q;
   wire [DATA_W-1:0] rd_data;
   wire [DATA_W-1:0] bit_mask = DATA_W'(1) << INSTR.bit_sel;
   wire tested = |(rd_data & bit_mask);
   wire is_and = exec && INSTR.op == AND_IMMEDIATE_OP;
   wire is_set = exec && INSTR.op == BIT_SET_OP;
   wire is_clr = exec && INSTR.op == BIT_CLEAR_OP;
   wire is_tsc = exec && INSTR.op == TEST_SKIP_IF_CLEAR_OP;
   wire is_tss = exec && INSTR.op == TEST_SKIP_IF_SET_OP;
   wire is_call = exec && INSTR.op == INDIRECT_CALL_OP;
   wire is_clw = exec && INSTR.op == CLEAR_WORKING_OP;
   wire [DATA_W-1:0] and_res = work_q & INSTR.imm;
   wire wr_en = is_set || is_clr;
   wire [DATA_W-1:0] wr_data = is_set ? (rd_data | bit_mask)
                                      : (rd_data & ~bit_mask);
   wire [PC_W-1:0] pc_next = pc_q + PC_STEP;
   wire [PC_W-1:0] call_target = {PAGE_PTR[PAGE_BITS-1:0], work_q};

   assign skip_d = (is_tsc && !tested)
                || (is_tss && tested);
   assign work_d = is_and ? and_res : (is_clw ? WORK_CLEARED : work_q);
   assign zero_d = is_and ? (and_res == WORK_CLEARED) : (is_clw ? 1'b1 : zero_q);
   assign pc_d = is_call ? call_target : (take ? pc_next : pc_q);

   blc_data_regs #(.DW(DATA_W), .AW(RADDR_W)) u_regs (
      .clk(MCLK),
      .rst_n(RST_N),
      .wr_en(wr_en),
      .wr_addr(INSTR.addr),
      .wr_data(wr_data),
      .rd_addr(INSTR.addr),
      .rd_data(rd_data),
      .peek_addr(PEEK_ADDR),
      .peek_q(peek_data)
   );

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         work_q <= WORK_RESET;
         zero_q <= ZERO_RESET;
         pc_q <= PC_RESET;
         skip_q <= 1'b0;
      end
      else
      begin
         work_q <= work_d;
         zero_q <= zero_d;
         pc_q <= pc_d;
         if (take)
            skip_q <= skip_d;
      end
   end

   // Second call cycle holds the fetch off for one clock
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_q <= ST_EXEC;
         ready_q <= 1'b1;
      end
      else
      begin
         case (state_q)
            ST_EXEC:
            begin
               if (is_call)
               begin
                  state_q <= ST_CALL2;
                  ready_q <= 1'b0;
               end
            end
            ST_CALL2:
            begin
               state_q <= ST_EXEC;
               ready_q <= 1'b1;
            end
            default:
            begin
               state_q <= ST_EXEC;
               ready_q <= 1'b1;
            end
         endcase
      end
   end

   // Stack wraps silently on overflow, as a small hardware stack does
   always_ff @(posedge MCLK)
   begin
      if (is_call)
         stack_mem[sp_q] <= pc_next;
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sp_q <= '0;
         top_q <= PC_RESET;
         PEEK_DATA <= '0;
      end
      else
      begin
         if (is_call)
         begin
            sp_q <= sp_q + SPW'(1);
            top_q <= pc_next;
         end
         PEEK_DATA <= peek_data;
      end
   end

   assign INSTR_READY = ready_q;
   assign WORK_REG = work_q;
   assign ZERO_FLAG = zero_q;
   assign PROG_CNT = pc_q;
   assign STACK_PTR = sp_q;
   assign STACK_TOP = top_q;
   assign SKIP_PEND = skip_q;

   // Checks sleep while reset is low
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   chk_and_result: assert property (is_and |=> work_q == $past(and_res)
      && zero_q == ($past(and_res) == WORK_CLEARED) && $stable(sp_q))
      else $error("and-immediate result or zero flag wrong");
   chk_bit_set: assert property (is_set |-> wr_en && wr_data[INSTR.bit_sel]
      && (wr_data & ~bit_mask) == (rd_data & ~bit_mask) ##1 $stable(zero_q))
      else $error("bit set wrong or flag changed");
   chk_skip_clear: assert property (is_tsc && !tested |=> skip_q && $stable(zero_q))
      else $error("skip-if-clear did not arm skip");
   chk_skip_discard: assert property (skip_q && take |=>
      $stable(work_q) && $stable(zero_q) && $stable(sp_q) && !skip_q
      && pc_q == $past(pc_next))
      else $error("skipped instruction was not a no-op");
   chk_skip_set: assert property (is_tss |=> skip_q == $past(tested))
      else $error("skip-if-set decision wrong");
   chk_call_push: assert property (is_call |=> !INSTR_READY
      && STACK_TOP == $past(pc_next) && $stable(zero_q) ##1 INSTR_READY)
      else $error("call push or two-cycle timing wrong");
   chk_call_target: assert property (is_call |=>
      pc_q == {$past(PAGE_PTR[PAGE_BITS-1:0]), $past(work_q)})
      else $error("call target wrong");
   chk_clear_work: assert property (is_clw |=> work_q == WORK_CLEARED && zero_q)
      else $error("clear-working failed");
   chk_bit_clear: assert property (is_clr |-> !wr_data[INSTR.bit_sel]
      && (wr_data & ~bit_mask) == (rd_data & ~bit_mask) ##1 $stable(zero_q))
      else $error("bit clear wrong or flag changed");
   chk_sp_advance: assert property (is_call |=> sp_q == $past(sp_q) + SPW'(1))
      else $error("stack pointer did not advance");
   chk_stack_write: assert property (is_call |=>
      stack_mem[$past(sp_q)] == $past(pc_next))
      else $error("return address not written to the stack");
   chk_pc_advance: assert property (take && !is_call |=>
      pc_q == $past(pc_next))
      else $error("counter did not advance by one");

   cov_skip_taken: cover property (is_tss && tested ##1 take);
   cov_call_back: cover property (is_call ##2 take);
   cov_and_zero: cover property (is_and && and_res == WORK_CLEARED);
   cov_set_then_test: cover property (is_set ##1 is_tsc);
   cov_clear_skip: cover property (is_tsc && !tested ##1 take);
endmodule

// ===== bit_logic_call_instructions_test.sv
/*
 Self-checking bench for blc_core: random and hand-picked instructions
 run against a reference model. Assumes blc_pkg is compiled first.
*/
`timescale 1ns/1ps
module bit_logic_call_instructions_test;
   import blc_pkg::*;
   localparam int SN = 4;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic instr_valid = 1'b0;
   blc_instr_t instr = '0;
   logic [DATA_W-1:0] page_ptr = 8'h00;
   logic [RADDR_W-1:0] peek_addr = 7'h00;
   logic instr_ready;
   logic [DATA_W-1:0] work_reg;
   logic zero_flag;
   logic [PC_W-1:0] prog_cnt;
   logic [$clog2(SN)-1:0] stack_ptr;
   logic [PC_W-1:0] stack_top;
   logic skip_pend;
   logic [DATA_W-1:0] peek_data;
   logic [DATA_W-1:0] m_w;
   logic m_z;
   logic m_skip;
   logic m_hold;
   logic [PC_W-1:0] m_pc;
   logic [PC_W-1:0] m_top;
   logic [$clog2(SN)-1:0] m_sp;
   logic [DATA_W-1:0] m_r [128];
   int err_total = 0;
   int num_checks = 0;

   always #10 mclk = ~mclk;

   // Small stack so the pointer wraps within the run
   blc_core #(.STACK_N(SN)) u_blc_core (.MCLK(mclk), .RST_N(rst_n), .INSTR_VALID(instr_valid),
      .INSTR(instr), .PAGE_PTR(page_ptr), .PEEK_ADDR(peek_addr), .INSTR_READY(instr_ready),
      .WORK_REG(work_reg), .ZERO_FLAG(zero_flag), .PROG_CNT(prog_cnt), .STACK_PTR(stack_ptr),
      .STACK_TOP(stack_top), .SKIP_PEND(skip_pend), .PEEK_DATA(peek_data));

   function automatic blc_instr_t mk(input blc_op_t op, input logic [RADDR_W-1:0] a,
      input logic [BIT_W-1:0] b, input logic [DATA_W-1:0] imm);
      return '{op, a, b, imm};
   endfunction

   // Both ends of the register range, sixteen places in all
   function automatic logic [RADDR_W-1:0] pick_addr(input logic [3:0] r);
      return {{4{r[3]}}, r[2:0]};
   endfunction

   task automatic stop_test();
      if (err_total == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic model_reset();
      m_w = WORK_RESET;
      m_z = ZERO_RESET;
      m_pc = PC_RESET;
      m_top = PC_RESET;
      m_sp = '0;
      m_skip = 1'b0;
      m_hold = 1'b0;
   endtask

   function automatic void model(input blc_instr_t ins, input logic [DATA_W-1:0] pg);
      logic b;
      b = m_r[ins.addr][ins.bit_sel];
      m_hold = !m_skip && ins.op == INDIRECT_CALL_OP;
      m_pc = m_pc + PC_STEP;
      if (m_skip)
         m_skip = 1'b0;
      else
         case (ins.op)
            AND_IMMEDIATE_OP:
            begin
               m_w = m_w & ins.imm;
               m_z = (m_w == 8'h00);
            end
            BIT_SET_OP: m_r[ins.addr][ins.bit_sel] = 1'b1;
            BIT_CLEAR_OP: m_r[ins.addr][ins.bit_sel] = 1'b0;
            TEST_SKIP_IF_CLEAR_OP: m_skip = ~b;
            TEST_SKIP_IF_SET_OP: m_skip = b;
            INDIRECT_CALL_OP:
            begin
               m_top = m_pc;
               m_sp = m_sp + 1'b1;
               m_pc = {pg[2:0], m_w};
            end
            CLEAR_WORKING_OP:
            begin
               m_w = 8'h00;
               m_z = 1'b1;
            end
            default: ;
         endcase
   endfunction

   task automatic compare_all(input logic rdy);
      check(16'(work_reg), 16'(m_w));
      check(16'(zero_flag), 16'(m_z));
      check(16'(prog_cnt), 16'(m_pc));
      check(16'(stack_ptr), 16'(m_sp));
      check(16'(stack_top), 16'(m_top));
      check(16'(skip_pend), 16'(m_skip));
      check(16'(instr_ready), 16'(rdy));
   endtask

   task automatic do_reset();
      instr_valid = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      model_reset();
      compare_all(1'b1);
      rst_n = 1'b1;
   endtask

   task automatic exec(input blc_instr_t ins, input logic [DATA_W-1:0] pg);
      int n;
      n = 0;
      instr_valid = 1'b1;
      instr = ins;
      page_ptr = pg;
      while (instr_ready !== 1'b1)
      begin
         @(posedge mclk);
         #1;
         n++;
         if (n > 4)
         begin
            err_total++;
            stop_test();
         end
      end
      // A call holds fetch off for exactly one clock
      check(16'(n), 16'(m_hold));
      @(posedge mclk);
      #1;
      model(ins, pg);
      compare_all(!m_hold);
   endtask

   task automatic peek_all();
      for (int i = 0; i < 16; i++)
      begin
         peek_addr = pick_addr(4'(i));
         repeat (2) @(posedge mclk);
         #1;
         check(16'(peek_data), 16'(m_r[peek_addr]));
      end
   endtask

   initial
   begin
      void'($urandom(48729));
      model_reset();
      repeat (8) @(posedge mclk);
      #1;
      compare_all(1'b1);
      rst_n = 1'b1;
      // File powers up unknown, so clear every bit used later
      for (int i = 0; i < 128; i++)
         exec(mk(BIT_CLEAR_OP, pick_addr(4'(i / 8)), 3'(i % 8), 8'h00), 8'h00);
      foreach (m_r[i])
         if (m_r[i] === 8'hXX)
            m_r[i] = 8'h00;
      for (int i = 0; i < 5; i++)
         exec(mk(BIT_SET_OP, 7'h7F, 3'(i == 4 ? 2 : 2 * i + 1 - (i > 1)), 8'h00), 8'h00);
      exec(mk(TEST_SKIP_IF_CLEAR_OP, 7'h7F, 3'h0, 8'h00), 8'h00);
      exec(mk(INDIRECT_CALL_OP, 7'h00, 3'h0, 8'h00), 8'h05);
      exec(mk(TEST_SKIP_IF_SET_OP, 7'h7F, 3'h3, 8'h00), 8'h00);
      exec(mk(TEST_SKIP_IF_SET_OP, 7'h7F, 3'h0, 8'h00), 8'h00);
      exec(mk(TEST_SKIP_IF_SET_OP, 7'h7F, 3'h0, 8'h00), 8'h00);
      exec(mk(INDIRECT_CALL_OP, 7'h00, 3'h0, 8'h00), 8'hFA);
      exec(mk(INDIRECT_CALL_OP, 7'h00, 3'h0, 8'h00), 8'h07);
      exec(mk(AND_IMMEDIATE_OP, 7'h00, 3'h0, 8'h5A), 8'h00);
      exec(mk(AND_IMMEDIATE_OP, 7'h00, 3'h0, 8'hAF), 8'h00);
      exec(mk(CLEAR_WORKING_OP, 7'h00, 3'h0, 8'h00), 8'h00);
      exec(mk(AND_IMMEDIATE_OP, 7'h00, 3'h0, 8'hAF), 8'h00);
      // Drop valid first, or the last word is taken again while waiting
      instr_valid = 1'b0;
      peek_addr = 7'h7F;
      repeat (2) @(posedge mclk);
      #1;
      check(16'(peek_data), 16'h005E);
      do_reset();
      for (int i = 0; i < 600; i++)
      begin
         // Resets now and then bring back a non-zero working register
         if (i % 150 == 149)
            do_reset();
         exec(mk(blc_op_t'(3'($urandom_range(7, 0))), pick_addr(4'($urandom)),
            3'($urandom), 8'($urandom)), 8'($urandom));
      end
      instr_valid = 1'b0;
      peek_all();
      stop_test();
   end
endmodule
